// ---- shared/tpcc_pkg.sv ----
// tpcc_pkg: constants for the timer pair common control block
// assumes a 25 MHz system clock and an avalon-mm register slave
// Function
// R01: power register holds four per-timer clock enables
// R02: pair enable low withholds clock from both
// R03: software enables pair before touching controls
// R04: combine low: each timer to own pins
// R05: combine high: AND of outputs on upper
// R06: combine high: lower pins held high; code drives them from func_out_lower_in instead
// R07: cascade bit selects 8-bit or 16-bit chain
// R08: upper run starts, stops, clears upper/pair
// R09: lower run starts; clearing stops and zeroes
// R10: deep stop entry clears both run bits
// R11: control register upper nibble reads zero
// R12: combine and cascade frozen while running
// R13: start write also updates combine and cascade
// R14: cascaded modes use upper clock select
// R15: stopped low clock gives no source clock
// R16: full-speed clock select divider map
// R17: slow modes allow only codes 000,001,111
// R18: event modes count pin; cascade uses lower pin; code gives the upper timer no pin outside cascade
package tpcc_pkg;
	localparam logic [11:0] TPCC_CTRL_OFS = 12'h02c;
	localparam logic [11:0] TPCC_PWR_OFS = 12'hf74;
	localparam logic [11:0] TPCC_CNT_OFS = 12'h030;
	localparam logic [7:0] TPCC_CTRL_RST = 8'h00;
	localparam logic [7:0] TPCC_PWR_RST = 8'h00;
	localparam int TPCC_B_RUN_LO = 0;
	localparam int TPCC_B_RUN_UP = 1;
	localparam int TPCC_B_CASC = 2;
	localparam int TPCC_B_COMB = 3;
	localparam int TPCC_B_PAIR_EN = 4;
	localparam logic [7:0] TPCC_PWR_MASK = 8'h33;
	localparam int TPCC_PRE_W = 11;
	localparam int TPCC_LOWDIV_W = 4;
	typedef enum logic [1:0] {
		TPCC_SRC_GEAR = 2'b00,
		TPCC_SRC_LOW = 2'b01,
		TPCC_SRC_PIN = 2'b10,
		TPCC_SRC_NONE = 2'b11
	} tpcc_src_e;
endpackage

// ---- logic/tpcc_top.sv ----
// tpcc_top: shared control of an 8-bit timer pair with a demo counter core
// assumes avalon-mm master on clk_in; low clock and event pin are asynchronous levels
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tpcc_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// avalon-mm slave
	input wire logic [11:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	// system state
	input wire logic deep_stop_in,
	input wire logic slow_mode_in,
	input wire logic low_clk_sel_in,
	input wire logic low_clk_osc_in,
	input wire logic low_freq_clock_in,
	input wire logic event_input_pin_in,
	input wire logic [1:0] ext_src_in,
	input wire logic [2:0] clk_sel_lower_in,
	input wire logic [2:0] clk_sel_upper_in,
	// timer outputs from the mode logic
	input wire logic tmr_lower_in,
	input wire logic tmr_upper_in,
	input wire logic func_out_lower_in,
	// pins and clock enables
	output logic width_pulse_pin_lower_out,
	output logic prog_pulse_pin_lower_out,
	output logic width_pulse_pin_upper_out,
	output logic prog_pulse_pin_upper_out,
	output logic [3:0] unit_clk_en_out,
	output logic [1:0] tick_out,
	output logic [15:0] count_out
);
	import tpcc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [7:0] pwr_reg;
	logic [3:0] ctrl_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic wr_ctrl, wr_pwr, pair_en, running;
	logic [2:0] lo_sync_reg, pin_sync_reg;
	logic [TPCC_PRE_W-1:0] pre_reg;
	logic [TPCC_LOWDIV_W-1:0] lowdiv_reg;
	logic [7:0] cnt_lo_reg, cnt_up_reg;
	logic tick_lo, tick_up, low_edge, pin_fall;
	logic lo_lvl_reg, pin_lvl_reg;

	function automatic logic gear_tick(input logic [2:0] sel, input logic [10:0] pre);
		case (sel)
			3'h0: gear_tick = &pre[10:0];
			3'h1: gear_tick = &pre[9:0];
			3'h2: gear_tick = &pre[7:0];
			3'h3: gear_tick = &pre[5:0];
			3'h4: gear_tick = &pre[3:0];
			3'h5: gear_tick = &pre[1:0];
			3'h6: gear_tick = pre[0];
			default: gear_tick = 1'b1;
		endcase
	endfunction

	// low clock edges divided by 16, 8 or 4 for codes 000, 001, 111
	function automatic logic low_tick(input logic [2:0] sel, input logic [3:0] dv, input logic e);
		case (sel)
			3'h0: low_tick = e & (&dv[3:0]);
			3'h1: low_tick = e & (&dv[2:0]);
			3'h7: low_tick = e & (&dv[1:0]);
			default: low_tick = 1'b0;
		endcase
	endfunction

	function automatic logic src_tick(input logic ext, input logic [2:0] sel, input logic g,
			input logic l, input logic p);
		logic low_path;
		low_path = slow_mode_in || (low_clk_sel_in && (sel == 3'h0 || sel == 3'h1));
		if (ext)
			src_tick = p; // R18
		else if (low_path)
			src_tick = low_clk_osc_in && l; // R15 R16 R17
		else
			src_tick = g; // R16
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then answer
	assign waitrequest_out = (read_in || write_in) && !ack_reg;
	assign wr_ctrl = write_in && ack_reg && address_in == TPCC_CTRL_OFS && byteenable_in[0];
	assign wr_pwr = write_in && ack_reg && address_in == TPCC_PWR_OFS && byteenable_in[0];
	assign readdata_out = rdata_reg;

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			ack_reg <= 1'b0;
		else
			ack_reg <= (read_in || write_in) && !ack_reg;
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			rdata_reg <= 32'h0000_0000;
		else if (read_in && !ack_reg) begin
			case (address_in)
				TPCC_CTRL_OFS: rdata_reg <= {28'h000_0000, ctrl_reg}; // R11
				TPCC_PWR_OFS: rdata_reg <= {24'h00_0000, pwr_reg};
				TPCC_CNT_OFS: rdata_reg <= {16'h0000, cnt_up_reg, cnt_lo_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			pwr_reg <= TPCC_PWR_RST; // R01
		else if (wr_pwr)
			pwr_reg <= writedata_in[7:0]; // R01
	end
	assign pair_en = pwr_reg[TPCC_B_PAIR_EN];
	assign unit_clk_en_out = {pwr_reg[5], pwr_reg[4], pwr_reg[1], pwr_reg[0]}; // R01
	assign running = ctrl_reg[TPCC_B_RUN_LO] || ctrl_reg[TPCC_B_RUN_UP];

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			ctrl_reg <= TPCC_CTRL_RST[3:0];
		else if (deep_stop_in) begin
			ctrl_reg[TPCC_B_RUN_LO] <= 1'b0; // R10
			ctrl_reg[TPCC_B_RUN_UP] <= 1'b0; // R10
		end else if (wr_ctrl) begin
			ctrl_reg[TPCC_B_RUN_LO] <= writedata_in[TPCC_B_RUN_LO]; // R09
			ctrl_reg[TPCC_B_RUN_UP] <= writedata_in[TPCC_B_RUN_UP]; // R08
			if (!running) begin
				ctrl_reg[TPCC_B_CASC] <= writedata_in[TPCC_B_CASC]; // R12 R13
				ctrl_reg[TPCC_B_COMB] <= writedata_in[TPCC_B_COMB]; // R12 R13
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// three-stage synchronisers; change counts when stages two and three agree
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			lo_sync_reg <= 3'h0;
			pin_sync_reg <= 3'h7;
		end else begin
			lo_sync_reg <= {lo_sync_reg[1:0], low_freq_clock_in};
			pin_sync_reg <= {pin_sync_reg[1:0], event_input_pin_in};
		end
	end
	// a level is taken once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			lo_lvl_reg <= 1'b0;
			pin_lvl_reg <= 1'b1;
		end else begin
			if (lo_sync_reg[1] == lo_sync_reg[2])
				lo_lvl_reg <= lo_sync_reg[2];
			if (pin_sync_reg[1] == pin_sync_reg[2])
				pin_lvl_reg <= pin_sync_reg[2];
		end
	end
	assign low_edge = lo_sync_reg[1] == lo_sync_reg[2] && lo_sync_reg[2] && !lo_lvl_reg;
	assign pin_fall = pin_sync_reg[1] == pin_sync_reg[2] && !pin_sync_reg[2] && pin_lvl_reg;

	// prescalers run only while the pair clock is enabled
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pre_reg <= '0;
			lowdiv_reg <= '0;
		end else if (pair_en) begin // R02
			pre_reg <= pre_reg + 1'b1;
			if (low_edge && low_clk_osc_in)
				lowdiv_reg <= lowdiv_reg + 1'b1;
		end
	end

	always_comb begin
		tick_lo = pair_en && src_tick(ext_src_in[0], clk_sel_lower_in, // R02
			gear_tick(clk_sel_lower_in, pre_reg), low_tick(clk_sel_lower_in, lowdiv_reg, low_edge),
			pin_fall);
		// cascade takes upper select and the lower pin
		tick_up = pair_en && src_tick(ext_src_in[1], clk_sel_upper_in, // R14 R18
			gear_tick(clk_sel_upper_in, pre_reg), low_tick(clk_sel_upper_in, lowdiv_reg, low_edge),
			ctrl_reg[TPCC_B_CASC] ? pin_fall : 1'b0);
	end
	assign tick_out = {tick_up, tick_lo};

	////////////////////////////////////////////////////////////////////////
	// cascade: lower byte counts upper ticks, its carry steps the upper byte
	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			cnt_lo_reg <= 8'h00;
		else if (ctrl_reg[TPCC_B_CASC]) begin
			if (!ctrl_reg[TPCC_B_RUN_UP])
				cnt_lo_reg <= 8'h00; // R08
			else if (tick_up)
				cnt_lo_reg <= cnt_lo_reg + 8'h01; // R07
		end else if (!ctrl_reg[TPCC_B_RUN_LO])
			cnt_lo_reg <= 8'h00; // R09
		else if (tick_lo)
			cnt_lo_reg <= cnt_lo_reg + 8'h01; // R09
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			cnt_up_reg <= 8'h00;
		else if (!ctrl_reg[TPCC_B_RUN_UP])
			cnt_up_reg <= 8'h00; // R08
		else if (ctrl_reg[TPCC_B_CASC]) begin
			if (tick_up && cnt_lo_reg == 8'hff)
				cnt_up_reg <= cnt_up_reg + 8'h01; // R07
		end else if (tick_up)
			cnt_up_reg <= cnt_up_reg + 8'h01; // R08
	end
	assign count_out = {cnt_up_reg, cnt_lo_reg};

	////////////////////////////////////////////////////////////////////////
	// combine hides timer 00 from its own pins
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			width_pulse_pin_lower_out <= 1'b1;
			prog_pulse_pin_lower_out <= 1'b1;
			width_pulse_pin_upper_out <= 1'b1;
			prog_pulse_pin_upper_out <= 1'b1;
		end else if (ctrl_reg[TPCC_B_COMB]) begin
			width_pulse_pin_lower_out <= func_out_lower_in; // R06
			prog_pulse_pin_lower_out <= func_out_lower_in; // R06
			width_pulse_pin_upper_out <= tmr_lower_in & tmr_upper_in; // R05
			prog_pulse_pin_upper_out <= tmr_lower_in & tmr_upper_in; // R05
		end else begin
			width_pulse_pin_lower_out <= tmr_lower_in; // R04
			prog_pulse_pin_lower_out <= tmr_lower_in; // R04
			width_pulse_pin_upper_out <= tmr_upper_in; // R04
			prog_pulse_pin_upper_out <= tmr_upper_in; // R04
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks on the bus, register, counter and pin rules
	// a request opens with exactly one wait cycle
	sequence s_wait_cycle;
		waitrequest_out ##1 !waitrequest_out;
	endsequence
	a_wait_one: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$rose(read_in || write_in) |-> s_wait_cycle)
		else $error("answer not after one wait cycle");
	a_nibble_zero: assert property (@(posedge clk_in) disable iff (!resetn_in) // R11
		read_in && !ack_reg && address_in == TPCC_CTRL_OFS |=> rdata_reg[31:4] == 28'h0)
		else $error("control upper bits not zero");
	a_freeze_cfg: assert property (@(posedge clk_in) disable iff (!resetn_in) // R12
		running && !deep_stop_in |=> $stable(ctrl_reg[3:2]))
		else $error("combine or cascade changed while running");
	a_start_cfg: assert property (@(posedge clk_in) disable iff (!resetn_in) // R13
		wr_ctrl && !running && !deep_stop_in |=> ctrl_reg[3:2] == $past(writedata_in[3:2]))
		else $error("start write lost config");
	a_deep_stop: assert property (@(posedge clk_in) disable iff (!resetn_in) // R10
		deep_stop_in |=> ctrl_reg[1:0] == 2'b00)
		else $error("run bits survive deep stop");
	a_no_clock: assert property (@(posedge clk_in) disable iff (!resetn_in) // R02
		!pair_en |-> tick_lo == 1'b0 && tick_up == 1'b0)
		else $error("tick without pair clock");
	a_low_dead: assert property (@(posedge clk_in) disable iff (!resetn_in) // R15
		slow_mode_in && !low_clk_osc_in && ext_src_in == 2'b00 |-> tick_out == 2'b00)
		else $error("tick from stopped low clock");
	sequence s_lower_stopped;
		!ctrl_reg[TPCC_B_CASC] && !ctrl_reg[TPCC_B_RUN_LO] ##1 !ctrl_reg[TPCC_B_CASC];
	endsequence
	a_stop_clear: assert property (@(posedge clk_in) disable iff (!resetn_in) // R09
		s_lower_stopped |-> cnt_lo_reg == 8'h00)
		else $error("stopped lower counter not zero");
	a_comb_and: assert property (@(posedge clk_in) disable iff (!resetn_in) // R05
		ctrl_reg[TPCC_B_COMB] |=> width_pulse_pin_upper_out == ($past(tmr_lower_in) & $past(tmr_upper_in)))
		else $error("upper pin not the and of outputs");
	a_pwr_bits: assert property (@(posedge clk_in) disable iff (!resetn_in) // R01
		wr_pwr |=> unit_clk_en_out == {$past(writedata_in[5]), $past(writedata_in[4]),
			$past(writedata_in[1]), $past(writedata_in[0])})
		else $error("clock enables not from power register");
	a_lower_high: assert property (@(posedge clk_in) disable iff (!resetn_in) // R06
		ctrl_reg[TPCC_B_COMB] && func_out_lower_in |=> width_pulse_pin_lower_out && prog_pulse_pin_lower_out)
		else $error("lower pins not high under combine");
	a_own_pins: assert property (@(posedge clk_in) disable iff (!resetn_in) // R04
		!ctrl_reg[TPCC_B_COMB] |=> width_pulse_pin_lower_out == $past(tmr_lower_in)
			&& prog_pulse_pin_upper_out == $past(tmr_upper_in))
		else $error("timer output not on its own pins");
	a_upper_clear: assert property (@(posedge clk_in) disable iff (!resetn_in) // R08
		!ctrl_reg[TPCC_B_RUN_UP] |=> cnt_up_reg == 8'h00)
		else $error("stopped upper counter not zero");
	a_casc_step: assert property (@(posedge clk_in) disable iff (!resetn_in) // R07 R14
		ctrl_reg[TPCC_B_CASC] && ctrl_reg[TPCC_B_RUN_UP] && tick_up
		|=> count_out == $past(count_out) + 16'h0001)
		else $error("cascaded pair did not step as one counter");
	a_pin_source: assert property (@(posedge clk_in) disable iff (!resetn_in) // R18
		pair_en && ext_src_in[0] |-> tick_lo == pin_fall)
		else $error("event source not the pin edge");
	a_run_write: assert property (@(posedge clk_in) disable iff (!resetn_in) // R08 R09
		wr_ctrl && !deep_stop_in |=> ctrl_reg[1:0] == $past(writedata_in[1:0]))
		else $error("run bits not taken from write");
	a_gear_full: assert property (@(posedge clk_in) disable iff (!resetn_in) // R16
		pair_en && !ext_src_in[0] && !slow_mode_in && clk_sel_lower_in == 3'h7 |-> tick_lo)
		else $error("full gear clock gave no tick");
endmodule // tpcc_top
`default_nettype wire

// ---- testbench/tpcc_top_tb.sv ----
// tpcc_top_tb: self-checking bench for the timer pair common control block
// assumes tpcc_pkg and tpcc_top compiled first; drives the avalon-mm slave directly
`timescale 1ns/100ps
`default_nettype none
module tpcc_top_tb;
	import tpcc_pkg::*;
	logic clk_in, resetn_in, read_in, write_in, deep_stop_in, slow_mode_in;
	logic low_clk_sel_in, low_clk_osc_in, low_freq_clock_in, event_input_pin_in;
	logic tmr_lower_in, tmr_upper_in, func_out_lower_in, waitrequest_out;
	logic [11:0] address_in;
	logic [31:0] writedata_in, readdata_out, rd;
	logic [3:0] byteenable_in, unit_clk_en_out;
	logic [1:0] ext_src_in, tick_out;
	logic [2:0] clk_sel_lower_in, clk_sel_upper_in;
	logic wl, pl, wu, pu;
	logic [15:0] count_out;
	int fails = 0;
	int comparisons = 0;
	tpcc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .address_in(address_in),
		.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
		.byteenable_in(byteenable_in), .readdata_out(readdata_out),
		.waitrequest_out(waitrequest_out), .deep_stop_in(deep_stop_in),
		.slow_mode_in(slow_mode_in), .low_clk_sel_in(low_clk_sel_in),
		.low_clk_osc_in(low_clk_osc_in), .low_freq_clock_in(low_freq_clock_in),
		.event_input_pin_in(event_input_pin_in), .ext_src_in(ext_src_in),
		.clk_sel_lower_in(clk_sel_lower_in), .clk_sel_upper_in(clk_sel_upper_in),
		.tmr_lower_in(tmr_lower_in), .tmr_upper_in(tmr_upper_in),
		.func_out_lower_in(func_out_lower_in), .width_pulse_pin_lower_out(wl),
		.prog_pulse_pin_lower_out(pl), .width_pulse_pin_upper_out(wu),
		.prog_pulse_pin_upper_out(pu), .unit_clk_en_out(unit_clk_en_out),
		.tick_out(tick_out), .count_out(count_out));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// low clock source keeps toggling; selection and low_clk_osc_in decide whether it counts
	initial begin
		low_freq_clock_in = 1'b0;
		forever begin
			repeat (4) @(posedge clk_in);
			low_freq_clock_in <= ~low_freq_clock_in;
		end
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// one avalon transfer: hold the request until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		address_in <= a;
		writedata_in <= {24'h0, d};
		write_in <= wr;
		read_in <= ~wr;
		do begin
			@(posedge clk_in);
			n++;
		end while (waitrequest_out !== 1'b0 && n < 50);
		rd = readdata_out;
		if (n >= 50) fails++;
		write_in <= 1'b0;
		read_in <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(nm, rd, {24'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn_in, read_in, write_in, deep_stop_in, slow_mode_in, low_clk_sel_in} = '0;
		{low_clk_osc_in, event_input_pin_in, tmr_lower_in, tmr_upper_in} = 4'hf;
		{address_in, writedata_in, ext_src_in, clk_sel_lower_in, clk_sel_upper_in} = '0;
		func_out_lower_in = 1'b1;
		byteenable_in = 4'hf;
		wt(12);
		resetn_in <= 1'b1;
		rchk("ctrl", TPCC_CTRL_OFS, 8'h00);
		rchk("power", TPCC_PWR_OFS, 8'h00);
		rchk("unmapped", 12'h100, 8'h00);
		xfer(1'b1, TPCC_PWR_OFS, 8'h33);
		rchk("power", TPCC_PWR_OFS, 8'h33);
		chk("clk_en", unit_clk_en_out, 4'hf);
		xfer(1'b1, TPCC_PWR_OFS, 8'hcc);
		rchk("power", TPCC_PWR_OFS, 8'hcc);
		chk("clk_en", unit_clk_en_out, 4'h0);
		clk_sel_lower_in <= 3'b111;
		wt(4);
		chk("gated tick", tick_out, 2'b00);
		chk("gated count", count_out, 16'h0);
		xfer(1'b1, TPCC_PWR_OFS, 8'h10);
		wt(1);
		chk("clk_en", unit_clk_en_out, 4'b0100);
		chk("lower tick", tick_out[0], 1'b1);
		$display("test power done");
		xfer(1'b1, TPCC_CTRL_OFS, 8'hf0);
		rchk("ctrl nibble", TPCC_CTRL_OFS, 8'h00);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		wt(20);
		chk("lower runs", count_out[7:0] != 8'h0, 1'b1);
		chk("upper idle", count_out[15:8], 8'h00);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		wt(2);
		chk("lower cleared", count_out, 16'h0);
		$display("test independent done");
		xfer(1'b1, TPCC_CTRL_OFS, 8'h0d);
		rchk("start write", TPCC_CTRL_OFS, 8'h0d);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		rchk("frozen", TPCC_CTRL_OFS, 8'h0d);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		rchk("stop keeps", TPCC_CTRL_OFS, 8'h0c);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		rchk("stopped", TPCC_CTRL_OFS, 8'h00);
		$display("test freeze done");
		for (int c = 0; c < 2; c++) begin
			xfer(1'b1, TPCC_CTRL_OFS, c[0] ? 8'h08 : 8'h00);
			for (int k = 0; k < 4; k++) begin
				tmr_lower_in <= k[0];
				tmr_upper_in <= k[1];
				wt(4);
				chk("upper pins", {wu, pu}, c[0] ? {2{k[0] & k[1]}} : {2{k[1]}});
				chk("lower pins", {wl, pl}, c[0] ? 2'b11 : {2{k[0]}});
			end
		end
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		$display("test pins done");
		xfer(1'b1, TPCC_CTRL_OFS, 8'h03);
		@(posedge clk_in);
		deep_stop_in <= 1'b1;
		@(posedge clk_in);
		deep_stop_in <= 1'b0;
		rchk("deep stop", TPCC_CTRL_OFS, 8'h00);
		$display("test deep stop done");
		clk_sel_upper_in <= 3'b111;
		clk_sel_lower_in <= 3'b000;
		xfer(1'b1, TPCC_CTRL_OFS, 8'h06);
		wt(300);
		chk("cascade carry", count_out > 16'h00ff, 1'b1);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		wt(2);
		chk("pair cleared", count_out, 16'h0);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		$display("test cascade done");
		ext_src_in <= 2'b01;
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		for (int i = 0; i < 3; i++) begin
			event_input_pin_in <= 1'b0;
			wt(4);
			event_input_pin_in <= 1'b1;
			wt(4);
		end
		wt(6);
		chk("event count", count_out, 16'h0003);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		ext_src_in <= 2'b00;
		low_clk_sel_in <= 1'b1;
		low_clk_osc_in <= 1'b0;
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		wt(300);
		chk("dead low clock", count_out, 16'h0);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		low_clk_osc_in <= 1'b1;
		clk_sel_lower_in <= 3'b001;
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		wt(300);
		chk("low clock div", count_out[7:0] != 8'h0, 1'b1);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		slow_mode_in <= 1'b1;
		clk_sel_lower_in <= 3'b111;
		low_clk_osc_in <= 1'b0;
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		wt(100);
		chk("slow dead clock", count_out, 16'h0);
		xfer(1'b1, TPCC_CTRL_OFS, 8'h00);
		low_clk_osc_in <= 1'b1;
		xfer(1'b1, TPCC_CTRL_OFS, 8'h01);
		wt(100);
		chk("slow low clock", count_out[7:0] != 8'h0, 1'b1);
		$display("test sources done");
		end_sim();
	end
endmodule // tpcc_top_tb
`default_nettype wire
